// File: design/fsp_top.sv
/*
 * Flash section protection: section map, directional write checks, boot lock,
 * code write protect, page buffer and page command issue, APB register slave.
 * Assumes the CPU presents the address of the issuing instruction on cpu_pc and
 * the array side holds nvm_op_done high for one cycle when an operation ends.
 */
// Contract
// [RL1] Flash is programmed and erased only as whole pages.
// [RL2] Sections run boot from zero, then application code, then application data.
// [RL3] Each boundary is its fuse value times 256 bytes.
// [RL4] Boot fuse zero makes the whole Flash boot section.
// [RL5] Code fuse zero with boot nonzero: code runs to end, no data.
// [RL6] Code fuse nonzero and not above boot: no code section, data to end.
// [RL7] Code fuse above boot: code between boundaries, data takes the rest.
// [RL8] A boundary beyond the last address falls back to the default fuse.
// [RL9] Vector table starts at code section, or boot section when selected.
// [RL10] Boot code may write code and data sections.
// [RL11] Code section code may write the data section.
// [RL12] Data section code may write neither Flash nor EEPROM.
// [RL13] The CPU never writes the boot section.
// [RL14] Boot lock blocks reading and fetching the boot section.
// [RL15] Boot lock is set only from boot code, acts after leaving it.
// [RL16] Code write protect rejects further updates of the code section.
// [RL17] EEPROM operations change only the marked bytes of a page.
// [RL18] Storing into the page buffer marks that byte for update.
// [RL19] Each buffer store keeps the AND of new and old data.
// [RL20] Chip erase clears Flash ignoring boot lock and code write protect.
// [RL21] The issuing instruction address decides the requesting section.
`timescale 1ns/1ps
`default_nettype none
module fsp_top
	import fsp_pkg::*;
#(
	parameter int FLASH_SIZE = FLASH_BYTES,
	parameter int PAGE       = PAGE_BYTES
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [7:0]                paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [7:0]                boot_end_fuse,
	input  wire logic [7:0]                app_code_end_fuse,
	input  wire logic [ADDR_W-1:0]         cpu_pc,
	input  wire logic                      cpu_req_valid,
	input  wire logic                      cpu_req_write,
	input  wire logic                      cpu_req_eeprom,
	input  wire logic [ADDR_W-1:0]         cpu_req_addr,
	input  wire logic [7:0]                cpu_req_wdata,
	output logic                           cpu_ack,
	output logic                           cpu_deny,
	output logic                           nvm_op_valid,
	output logic      [2:0]                nvm_op_code,
	output logic      [ADDR_W-1:0]         nvm_op_page,
	output logic                           nvm_op_eeprom,
	input  wire logic                      nvm_op_done,
	input  wire logic [$clog2(PAGE)-1:0]   nvm_buf_index,
	output logic      [7:0]                nvm_buf_data,
	output logic                           nvm_buf_mark,
	output logic                           boot_read_lock,
	output logic                           app_code_write_protect,
	output logic      [LIM_W-1:0]          vector_base
);
	localparam int PSH = $clog2(PAGE);

	logic [LIM_W-1:0]  boot_lim;
	logic [LIM_W-1:0]  code_lim;
	logic              map_valid;
	fsp_state_t        state_r;
	fsp_sec_t          pc_sec;
	fsp_sec_t          tgt_sec;
	fsp_sec_t          buf_sec;
	logic              lock_r;
	logic              wp_r;
	logic              ivs_r;
	logic              deny_flag_r;
	logic              ack_r;
	logic              cpu_deny_r;
	logic              op_valid_r;
	logic [2:0]        op_code_r;
	logic [ADDR_W-1:0] op_page_r;
	logic              op_ee_r;
	logic [ADDR_W-1:0] buf_page_r;
	logic              buf_ee_r;
	logic              buf_used_r;
	logic [LIM_W-1:0]  vec_r;
	logic              pready_r;
	logic              pslverr_r;
	logic [31:0]       prdata_r;
	logic              apb_acc;
	logic              apb_wr;
	logic              lock_eff;
	logic              store_go;
	logic              store_bad;
	logic              read_bad;
	logic              cmd_wr;
	logic [2:0]        cmd_val;
	logic              cmd_page_op;
	logic              cmd_ok;
	logic              cmd_bad;
	logic              buf_clear;
	logic              map_err;

	// May code in section src write the target? Checked per store and per page command.
	function automatic logic fsp_may_write(input fsp_sec_t src, input fsp_sec_t dst,
		input logic eeprom, input logic wp);
		if (src == FSP_SEC_DATA)
			return 1'b0;                                           // [RL12]
		else if (eeprom)
			return 1'b1;
		else if (dst == FSP_SEC_BOOT)
			return 1'b0;                                           // [RL13]
		else if (dst == FSP_SEC_CODE)
			return (src == FSP_SEC_BOOT) && !wp;                   // [RL10] [RL16]
		else
			return 1'b1;                                           // [RL10] [RL11]
	endfunction

	fsp_section_map #(
		.FLASH_SIZE        (FLASH_SIZE)
	) u_map (
		.pclk              (pclk),
		.presetn           (presetn),
		.boot_end_fuse     (boot_end_fuse),
		.app_code_end_fuse (app_code_end_fuse),
		.boot_lim_r        (boot_lim),
		.code_lim_r        (code_lim),
		.map_valid_r       (map_valid)
	);

	fsp_page_buffer #(
		.PAGE              (PAGE)
	) u_buf (
		.pclk              (pclk),
		.presetn           (presetn),
		.store             (store_go),
		.store_idx         (cpu_req_addr[PSH-1:0]),
		.store_data        (cpu_req_wdata),
		.clear             (buf_clear),
		.rd_idx            (nvm_buf_index),
		.rd_data_r         (nvm_buf_data),
		.rd_mark_r         (nvm_buf_mark)
	);

	always_comb begin
		pc_sec   = fsp_section_of(cpu_pc, boot_lim, code_lim);        // [RL21]
		tgt_sec  = fsp_section_of(cpu_req_addr, boot_lim, code_lim);
		buf_sec  = fsp_section_of({buf_page_r[ADDR_W-PSH-1:0], {PSH{1'b0}}},
			boot_lim, code_lim);
		// Lock bites only once the program counter is outside boot code
		lock_eff = lock_r && (pc_sec != FSP_SEC_BOOT);               // [RL15]
		apb_acc  = psel && penable && pready_r;
		apb_wr   = apb_acc && pwrite;
		map_err  = (paddr != OFF_CTRL) && (paddr != OFF_CMD) && (paddr != OFF_STATUS)
			&& (paddr != OFF_BOOT_LIM) && (paddr != OFF_CODE_LIM);
	end

	// CPU access checks; stores are refused while the array is busy
	always_comb begin
		store_bad = !map_valid || (state_r != FSP_ST_IDLE)
			|| !fsp_may_write(pc_sec, tgt_sec, cpu_req_eeprom, wp_r)
			|| (buf_used_r && (buf_ee_r != cpu_req_eeprom));
		store_go  = cpu_req_valid && cpu_req_write && !store_bad;
		read_bad  = !cpu_req_eeprom && lock_eff && (tgt_sec == FSP_SEC_BOOT); // [RL14]
	end

	// Command decode from a CMD register write
	always_comb begin
		cmd_wr      = apb_wr && (paddr == OFF_CMD);
		cmd_val     = pwdata[2:0];
		cmd_page_op = (cmd_val == CMD_WRITE_PG) || (cmd_val == CMD_ERASE_PG)
			|| (cmd_val == CMD_ERWR_PG);
		if (!map_valid || state_r != FSP_ST_IDLE)
			cmd_ok = 1'b0;
		else if (cmd_val == CMD_CHIP_ERS)
			cmd_ok = 1'b1;                                           // [RL20]
		else if (cmd_page_op)
			cmd_ok = buf_used_r && fsp_may_write(pc_sec, buf_sec, buf_ee_r, wp_r);
		else
			cmd_ok = 1'b0;
		cmd_bad   = cmd_wr && (cmd_page_op || cmd_val == CMD_CHIP_ERS) && !cmd_ok;
		buf_clear = (cmd_wr && cmd_val == CMD_BUF_CLR && state_r == FSP_ST_IDLE)
			|| (state_r == FSP_ST_BUSY && nvm_op_done);
	end

	// Operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= FSP_ST_IDLE;
			op_valid_r <= 1'b0;
			op_code_r  <= CMD_NONE;
			op_page_r  <= '0;
			op_ee_r    <= 1'b0;
		end else begin
			case (state_r)
				FSP_ST_IDLE: begin
					if (cmd_wr && cmd_ok) begin
						state_r    <= FSP_ST_BUSY;
						op_valid_r <= 1'b1;
						op_code_r  <= cmd_val;
						op_page_r  <= buf_page_r;                  // [RL1]
						op_ee_r    <= buf_ee_r && (cmd_val != CMD_CHIP_ERS); // [RL17]
					end
				end
				FSP_ST_BUSY: begin
					if (nvm_op_done) begin
						state_r    <= FSP_ST_IDLE;
						op_valid_r <= 1'b0;
						op_code_r  <= CMD_NONE;
					end
				end
				default: state_r <= FSP_ST_IDLE;
			endcase
		end
	end

	// Which page the buffer belongs to; the low address bits only pick a byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_page_r <= '0;
			buf_ee_r   <= 1'b0;
			buf_used_r <= 1'b0;
		end else if (buf_clear) begin
			buf_used_r <= 1'b0;
		end else if (store_go) begin
			buf_page_r <= {{PSH{1'b0}}, cpu_req_addr[ADDR_W-1:PSH]};  // [RL1]
			buf_ee_r   <= cpu_req_eeprom;
			buf_used_r <= 1'b1;
		end
	end

	// CPU answer, one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r      <= 1'b0;
			cpu_deny_r <= 1'b0;
		end else begin
			ack_r      <= cpu_req_valid;
			cpu_deny_r <= cpu_req_valid && (cpu_req_write ? store_bad : read_bad);
		end
	end

	// Control bits: lock and protect are sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= CTRL_RESET[CTRL_LOCK_BIT];
			wp_r   <= CTRL_RESET[CTRL_WP_BIT];
			ivs_r  <= CTRL_RESET[CTRL_IVS_BIT];
		end else if (apb_wr && paddr == OFF_CTRL) begin
			if (pwdata[CTRL_LOCK_BIT] && pc_sec == FSP_SEC_BOOT)
				lock_r <= 1'b1;                                      // [RL15]
			if (pwdata[CTRL_WP_BIT])
				wp_r <= 1'b1;                                        // [RL16]
			ivs_r <= pwdata[CTRL_IVS_BIT];
		end
	end

	// Deny flag: a new refusal wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			deny_flag_r <= 1'b0;
		else if ((cpu_req_valid && (cpu_req_write ? store_bad : read_bad)) || cmd_bad)
			deny_flag_r <= 1'b1;
		else if (apb_wr && paddr == OFF_STATUS && pwdata[STAT_DENY_BIT])
			deny_flag_r <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vec_r <= '0;
		else
			vec_r <= ivs_r ? '0 : boot_lim;                          // [RL9]
	end

	// APB slave: one wait state, so every access answers in its second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && (map_err
				|| (pwrite && paddr == OFF_CMD && state_r != FSP_ST_IDLE));
			prdata_r  <= '0;
			if (psel && penable && !pready_r && !pwrite) begin
				if (paddr == OFF_CTRL)
					prdata_r <= {29'h0, ivs_r, wp_r, lock_r};
				else if (paddr == OFF_CMD)
					prdata_r <= {29'h0, op_code_r};
				else if (paddr == OFF_STATUS)
					prdata_r <= {26'h0, map_valid, pc_sec, deny_flag_r,
						state_r == FSP_ST_BUSY};
				else if (paddr == OFF_BOOT_LIM)
					prdata_r <= {15'h0, boot_lim};
				else if (paddr == OFF_CODE_LIM)
					prdata_r <= {15'h0, code_lim};
			end
		end
	end

	always_comb begin
		prdata                 = prdata_r;
		pready                 = pready_r;
		pslverr                = pslverr_r;
		cpu_ack                = ack_r;
		cpu_deny               = cpu_deny_r;
		nvm_op_valid           = op_valid_r;
		nvm_op_code            = op_code_r;
		nvm_op_page            = op_page_r;
		nvm_op_eeprom          = op_ee_r;
		boot_read_lock         = lock_r;
		app_code_write_protect = wp_r;
		vector_base            = vec_r;
	end

	a_boot_never_written: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
		cpu_req_valid && cpu_req_write && !cpu_req_eeprom && tgt_sec == FSP_SEC_BOOT
		|=> cpu_ack && cpu_deny) else $error("boot section store was not refused");

	a_data_src_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
		cpu_req_valid && cpu_req_write && pc_sec == FSP_SEC_DATA
		|=> cpu_deny) else $error("store from data section was not refused");

	a_boot_writes_code: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
		cpu_req_valid && cpu_req_write && !cpu_req_eeprom && state_r == FSP_ST_IDLE
		&& map_valid && !wp_r && !buf_used_r && pc_sec == FSP_SEC_BOOT
		&& tgt_sec == FSP_SEC_CODE |=> !cpu_deny) else $error("boot code store refused");

	a_code_to_data: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
		cpu_req_valid && cpu_req_write && !cpu_req_eeprom && pc_sec == FSP_SEC_CODE
		&& tgt_sec != FSP_SEC_DATA |=> cpu_deny) else $error("code wrote outside data");

	a_code_writes_data: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
		cpu_req_valid && cpu_req_write && !cpu_req_eeprom && state_r == FSP_ST_IDLE
		&& map_valid && !buf_ee_r && pc_sec == FSP_SEC_CODE && tgt_sec == FSP_SEC_DATA
		|=> !cpu_deny) else $error("code store to data refused");

	a_wp_blocks_code: assert property (@(posedge pclk) disable iff (!presetn) // [RL16]
		wp_r && cpu_req_valid && cpu_req_write && !cpu_req_eeprom
		&& tgt_sec == FSP_SEC_CODE |=> cpu_deny) else $error("protected code updated");

	a_lock_blocks_read: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
		lock_r && pc_sec != FSP_SEC_BOOT && cpu_req_valid && !cpu_req_write
		&& !cpu_req_eeprom && tgt_sec == FSP_SEC_BOOT |=> cpu_deny)
		else $error("locked boot section was read");

	a_lock_from_boot: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
		$rose(lock_r) |-> $past(pc_sec) == FSP_SEC_BOOT && $past(apb_wr))
		else $error("boot lock set from outside boot code");

	a_chip_erase_free: assert property (@(posedge pclk) disable iff (!presetn) // [RL20]
		cmd_wr && cmd_val == CMD_CHIP_ERS && state_r == FSP_ST_IDLE && map_valid
		|=> nvm_op_valid && nvm_op_code == CMD_CHIP_ERS) else $error("chip erase refused");

	a_vector_place: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
		##1 $stable(ivs_r) && $stable(boot_lim) |-> vector_base == (ivs_r ? '0 : boot_lim))
		else $error("vector table base wrong");

	a_op_whole_page: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
		$rose(nvm_op_valid) && nvm_op_code != CMD_CHIP_ERS |-> $past(buf_used_r))
		else $error("page command without a loaded page");

endmodule
`default_nettype wire

// File: design/fsp_pkg.sv
/*
 * Shared constants and types of the Flash section protection block.
 * Assumes a byte-addressed Flash starting at address zero and a 16-bit CPU address space.
 */
package fsp_pkg;

	localparam int          ADDR_W        = 16;
	localparam int          LIM_W         = 17;
	localparam int          BLOCK_SHIFT   = 8;
	localparam int          FLASH_BYTES   = 16384;
	localparam int          PAGE_BYTES    = 64;
	localparam logic [7:0]  FUSE_DEFAULT  = 8'h00;

	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CMD       = 8'h04;
	localparam logic [7:0]  OFF_STATUS    = 8'h08;
	localparam logic [7:0]  OFF_BOOT_LIM  = 8'h0C;
	localparam logic [7:0]  OFF_CODE_LIM  = 8'h10;

	localparam int          CTRL_LOCK_BIT = 0;
	localparam int          CTRL_WP_BIT   = 1;
	localparam int          CTRL_IVS_BIT  = 2;
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_DENY_BIT = 1;
	localparam int          STAT_SEC_LSB  = 2;
	localparam int          STAT_MAP_BIT  = 5;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;

	localparam logic [2:0]  CMD_NONE      = 3'h0;
	localparam logic [2:0]  CMD_WRITE_PG  = 3'h1;
	localparam logic [2:0]  CMD_ERASE_PG  = 3'h2;
	localparam logic [2:0]  CMD_ERWR_PG   = 3'h3;
	localparam logic [2:0]  CMD_BUF_CLR   = 3'h4;
	localparam logic [2:0]  CMD_CHIP_ERS  = 3'h5;

	typedef enum logic [2:0] {
		FSP_SEC_BOOT = 3'b001,
		FSP_SEC_CODE = 3'b010,
		FSP_SEC_DATA = 3'b100
	} fsp_sec_t;

	typedef enum logic [1:0] {
		FSP_ST_IDLE = 2'b01,
		FSP_ST_BUSY = 2'b10
	} fsp_state_t;

	// Section that holds a Flash address, given the two effective limits
	function automatic fsp_sec_t fsp_section_of(input logic [ADDR_W-1:0] a,
		input logic [LIM_W-1:0] boot_lim, input logic [LIM_W-1:0] code_lim);
		logic [LIM_W-1:0] ax;
		ax = {1'b0, a};
		if (ax < boot_lim)
			return FSP_SEC_BOOT;
		else if (ax < code_lim)
			return FSP_SEC_CODE;
		else
			return FSP_SEC_DATA;
	endfunction

endpackage

// File: design/fsp_section_map.sv
/*
 * Captures the two section fuses after reset release and derives the section limits.
 * Assumes the fuse inputs are stable from reset onward.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_section_map
	import fsp_pkg::*;
#(
	parameter int FLASH_SIZE = FLASH_BYTES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [7:0]        boot_end_fuse,
	input  wire logic [7:0]        app_code_end_fuse,
	output logic      [LIM_W-1:0]  boot_lim_r,
	output logic      [LIM_W-1:0]  code_lim_r,
	output logic                   map_valid_r
);
	localparam logic [LIM_W-1:0] FLASH_LIM = LIM_W'(FLASH_SIZE);

	logic [LIM_W-1:0] boot_raw;
	logic [LIM_W-1:0] app_raw;
	logic [7:0]       boot_eff;
	logic [7:0]       app_eff;
	logic [LIM_W-1:0] boot_nxt;
	logic [LIM_W-1:0] code_nxt;

	always_comb begin
		boot_raw = {1'b0, boot_end_fuse, 8'h00};                     // [RL3]
		app_raw  = {1'b0, app_code_end_fuse, 8'h00};                 // [RL3]
		// Out-of-range boundary falls back to the default setting
		boot_eff = (boot_raw > FLASH_LIM) ? FUSE_DEFAULT : boot_end_fuse;       // [RL8]
		app_eff  = (app_raw > FLASH_LIM) ? FUSE_DEFAULT : app_code_end_fuse;    // [RL8]
		if (boot_eff == 8'h00) begin
			boot_nxt = FLASH_LIM;                                    // [RL4]
			code_nxt = FLASH_LIM;
		end else begin
			boot_nxt = {1'b0, boot_eff, 8'h00};                      // [RL2]
			if (app_eff == 8'h00)
				code_nxt = FLASH_LIM;                                // [RL5]
			else if (app_eff <= boot_eff)
				code_nxt = boot_nxt;                                 // [RL6]
			else
				code_nxt = {1'b0, app_eff, 8'h00};                   // [RL7]
		end
	end

	// Fuses are read once, after reset release, like straps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_lim_r  <= '0;
			code_lim_r  <= '0;
			map_valid_r <= 1'b0;
		end else if (!map_valid_r) begin
			boot_lim_r  <= boot_nxt;
			code_lim_r  <= code_nxt;
			map_valid_r <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// File: design/fsp_page_buffer.sv
/*
 * Shared page buffer with per-byte update marks.
 * Assumes store and clear are never asked for in the same cycle by the owner.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer
	import fsp_pkg::*;
#(
	parameter int PAGE = PAGE_BYTES
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     store,
	input  wire logic [$clog2(PAGE)-1:0]  store_idx,
	input  wire logic [7:0]               store_data,
	input  wire logic                     clear,
	input  wire logic [$clog2(PAGE)-1:0]  rd_idx,
	output logic      [7:0]               rd_data_r,
	output logic                          rd_mark_r
);
	logic [7:0]    mem_r  [PAGE];
	logic [PAGE-1:0] mark_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < PAGE; i++)
				mem_r[i] <= 8'hFF;
			mark_r <= '0;
		end else if (clear) begin
			for (int i = 0; i < PAGE; i++)
				mem_r[i] <= 8'hFF;
			mark_r <= '0;
		end else if (store) begin
			mem_r[store_idx]  <= mem_r[store_idx] & store_data;   // [RL19]
			mark_r[store_idx] <= 1'b1;                            // [RL18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_r <= 8'hFF;
			rd_mark_r <= 1'b0;
		end else begin
			rd_data_r <= mem_r[rd_idx];
			rd_mark_r <= mark_r[rd_idx];
		end
	end

endmodule
`default_nettype wire

// File: testbench/fsp_cpu_model.sv
/*
 * CPU core model: issues one fetch or store per call of access.
 * Assumes pclk from the bench and a one-cycle ack from the block.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model
	import fsp_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              cpu_ack,
	input  wire logic              cpu_deny,
	output logic      [ADDR_W-1:0] cpu_pc,
	output logic                   cpu_req_valid,
	output logic                   cpu_req_write,
	output logic                   cpu_req_eeprom,
	output logic      [ADDR_W-1:0] cpu_req_addr,
	output logic      [7:0]        cpu_req_wdata
);
	initial begin
		cpu_pc = '0;
		cpu_req_valid = 1'b0;
		cpu_req_write = 1'b0;
		cpu_req_eeprom = 1'b0;
		cpu_req_addr = '0;
		cpu_req_wdata = '0;
	end
	// Pc of the issuing instruction travels with the request
	task automatic access(input logic [15:0] pc, input logic wr, input logic ee,
		input logic [15:0] a, input logic [7:0] d, output logic dn);
		@(posedge pclk);
		cpu_pc <= pc;
		cpu_req_valid <= 1'b1;
		cpu_req_write <= wr;
		cpu_req_eeprom <= ee;
		cpu_req_addr <= a;
		cpu_req_wdata <= d;
		@(posedge pclk);
		cpu_req_valid <= 1'b0;
		// Stale lines flip so a late sample cannot pass by luck
		cpu_req_addr <= ~a;
		cpu_req_wdata <= ~d;
		#1;
		dn = (cpu_ack === 1'b1) ? cpu_deny : 1'bx;
	endtask
endmodule
`default_nettype wire

// File: testbench/fsp_top_tb_top.sv
/*
 * Self-checking bench of the Flash section protection block.
 * Assumes the CPU model beside it; the bench plays APB master and array side.
 */
`timescale 1ns/1ps
`default_nettype none
module fsp_top_tb_top;
	import fsp_pkg::*;
	localparam int FS = FLASH_BYTES;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, bf, cf, nvm_buf_data;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] cpu_pc, cpu_req_addr, nvm_op_page;
	logic [7:0] cpu_req_wdata;
	logic cpu_req_valid, cpu_req_write, cpu_req_eeprom, cpu_ack, cpu_deny, er, dn;
	logic nvm_op_valid, nvm_op_eeprom, nvm_op_done, nvm_buf_mark, lock, wp;
	logic [2:0] nvm_op_code;
	logic [5:0] idx;
	logic [16:0] vector_base;
	int fail_count = 0;
	int n_compared = 0;
	int seed = 32'hb481;
	int eb, ec;
	fsp_top fsp_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .boot_end_fuse(bf), .app_code_end_fuse(cf),
		.cpu_pc(cpu_pc), .cpu_req_valid(cpu_req_valid), .cpu_req_write(cpu_req_write),
		.cpu_req_eeprom(cpu_req_eeprom), .cpu_req_addr(cpu_req_addr),
		.cpu_req_wdata(cpu_req_wdata), .cpu_ack(cpu_ack), .cpu_deny(cpu_deny),
		.nvm_op_valid(nvm_op_valid), .nvm_op_code(nvm_op_code), .nvm_op_page(nvm_op_page),
		.nvm_op_eeprom(nvm_op_eeprom), .nvm_op_done(nvm_op_done), .nvm_buf_index(idx),
		.nvm_buf_data(nvm_buf_data), .nvm_buf_mark(nvm_buf_mark), .boot_read_lock(lock),
		.app_code_write_protect(wp), .vector_base(vector_base));
	fsp_cpu_model fsp_cpu_model_inst (.pclk(pclk), .cpu_ack(cpu_ack), .cpu_deny(cpu_deny),
		.cpu_pc(cpu_pc), .cpu_req_valid(cpu_req_valid), .cpu_req_write(cpu_req_write),
		.cpu_req_eeprom(cpu_req_eeprom), .cpu_req_addr(cpu_req_addr),
		.cpu_req_wdata(cpu_req_wdata));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(0, 1);
	endtask
	task automatic do_reset(input logic [7:0] b, input logic [7:0] c);
		presetn <= 1'b0;
		bf <= b;
		cf <= c;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// Fuse block size, with out-of-range values falling back to default
	function automatic int blk(input logic [7:0] f);
		return (f * 256 > FS) ? FUSE_DEFAULT * 256 : f * 256;
	endfunction
	task automatic op_cycle(input logic [2:0] code);
		int n;
		n = 0;
		#1;
		while (nvm_op_valid !== 1'b1 && n < 4) begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk(nvm_op_code, code);
		@(posedge pclk);
		nvm_op_done <= 1'b1;
		@(posedge pclk);
		nvm_op_done <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk(nvm_op_valid, 0);
	endtask
	initial begin
		logic [7:0] tb [9];
		logic [7:0] tc [9];
		tb = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h04, 8'h41, 8'h04, 8'h40, 8'h01};
		tc = '{8'h05, 8'h00, 8'h04, 8'h08, 8'h08, 8'h08, 8'h41, 8'h00, 8'hFF};
		{presetn, psel, penable, pwrite, nvm_op_done} = '0;
		{paddr, pwdata, bf, cf, idx} = '0;
		for (int i = 0; i < 13; i++) begin
			do_reset(i < 9 ? tb[i] : 8'($random(seed)), i < 9 ? tc[i] : 8'($random(seed)));
			eb = blk(bf);
			ec = blk(cf);
			if (eb == 0) begin
				eb = FS;
				ec = FS;
			end else if (ec == 0)
				ec = FS;
			else if (ec <= eb)
				ec = eb;
			apb(0, OFF_BOOT_LIM, 0);
			chk(rd, eb);
			apb(0, OFF_CODE_LIM, 0);
			chk(rd, ec);
			chk(vector_base, eb);
		end
		do_reset(8'h04, 8'h08);
		apb(0, 8'h40, 0);
		chk(er, 1);
		fsp_cpu_model_inst.access(16'h0100, 1, 0, 16'h0500, 8'hF0, dn);
		chk(dn, 0);
		fsp_cpu_model_inst.access(16'h0100, 1, 0, 16'h0900, 8'hF0, dn);
		chk(dn, 0);
		fsp_cpu_model_inst.access(16'h0600, 1, 0, 16'h0910, 8'hF0, dn);
		chk(dn, 0);
		fsp_cpu_model_inst.access(16'h0600, 1, 0, 16'h0510, 8'hF0, dn);
		chk(dn, 1);
		fsp_cpu_model_inst.access(16'h0100, 1, 0, 16'h0010, 8'hF0, dn);
		chk(dn, 1);
		fsp_cpu_model_inst.access(16'h0A00, 1, 0, 16'h0920, 8'hF0, dn);
		chk(dn, 1);
		fsp_cpu_model_inst.access(16'h0A00, 1, 1, 16'h0020, 8'hF0, dn);
		chk(dn, 1);
		fsp_cpu_model_inst.access(16'h0100, 1, 0, 16'h0940, 8'h55, dn);
		apb(1, OFF_CMD, CMD_ERASE_PG);
		op_cycle(CMD_ERASE_PG);
		chk(nvm_op_page, 16'h0940 / PAGE_BYTES);
		fsp_cpu_model_inst.access(16'h0600, 1, 1, 16'h0003, 8'hA5, dn);
		fsp_cpu_model_inst.access(16'h0600, 1, 1, 16'h0003, 8'h3C, dn);
		@(posedge pclk);
		idx <= 6'h03;
		repeat (2) @(posedge pclk);
		#1;
		chk({nvm_buf_mark, nvm_buf_data}, 9'h124);
		@(posedge pclk);
		idx <= 6'h04;
		repeat (2) @(posedge pclk);
		#1;
		chk({nvm_buf_mark, nvm_buf_data}, 9'h0FF);
		apb(1, OFF_CMD, CMD_ERWR_PG);
		op_cycle(CMD_ERWR_PG);
		chk({nvm_op_eeprom, nvm_op_page}, 17'h10000);
		apb(1, OFF_CMD, CMD_BUF_CLR);
		apb(1, OFF_CTRL, 32'h2);
		fsp_cpu_model_inst.access(16'h0100, 1, 0, 16'h0500, 8'h0F, dn);
		chk({wp, dn}, 2'b11);
		fsp_cpu_model_inst.access(16'h0600, 1, 0, 16'h0900, 8'h00, dn);
		chk(dn, 0);
		apb(1, OFF_CMD, CMD_WRITE_PG);
		op_cycle(CMD_WRITE_PG);
		chk(nvm_op_page, 16'h0900 / PAGE_BYTES);
		fsp_cpu_model_inst.access(16'h0600, 0, 0, 16'h0020, 8'h00, dn);
		apb(1, OFF_CTRL, 32'h3);
		chk({lock, dn}, 2'b00);
		fsp_cpu_model_inst.access(16'h0100, 0, 0, 16'h0020, 8'h00, dn);
		apb(1, OFF_CTRL, 32'h7);
		fsp_cpu_model_inst.access(16'h0100, 0, 0, 16'h0020, 8'h00, dn);
		chk({lock, dn}, 2'b10);
		fsp_cpu_model_inst.access(16'h0600, 0, 0, 16'h0020, 8'h00, dn);
		chk(dn, 1);
		chk(vector_base, 0);
		apb(1, OFF_CMD, CMD_CHIP_ERS);
		op_cycle(CMD_CHIP_ERS);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
